/* File: hw/eoc_irq_consts.vh */
/*
 Constants for the end-of-conversion interrupt reporting block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef EOC_IRQ_CONSTS_VH
`define EOC_IRQ_CONSTS_VH
`define EOC_TOP_BITS_ON    2'h3
`define MODE_SHUTDOWN      2'h0
`define FAULT_CNT_W        3
`define FLAG_HIGH_RST      1'h0
`define FLAG_LOW_RST       1'h0
`define ALERT_ACT_RST      1'h0
`define CONV_READY_RST     1'h0
`define ALERT_PIN_RST      1'h1
`define FAULT_SEL_ONE      2'h0
`define FAULT_SEL_TWO      2'h1
`define FAULT_SEL_FOUR     2'h2
`define FAULT_SEL_EIGHT    2'h3
`define FAULT_NUM_ONE      3'h1
`define FAULT_NUM_TWO      3'h2
`define FAULT_NUM_FOUR     3'h4
`define FAULT_NUM_EIGHT    3'h0
`endif

/* File: hw/fault_counter.v */
/*
 Consecutive-fault counter for one limit comparison.
 Assumes convDone pulses once per conversion with exceed valid beside it.
*/
`timescale 1ns/1ps
`include "eoc_irq_consts.vh"
module fault_counter (
   // Clock and reset.
   input  wire       clk_sys,
   input  wire       sys_rst,
   // Conversion event.
   input  wire       convDone,
   input  wire       exceed,
   input  wire [1:0] faultSel,
   // Result.
   output wire       faultMet
);
   reg  [`FAULT_CNT_W-1:0] count_reg;
   reg  [`FAULT_CNT_W-1:0] count_next;
   reg  [`FAULT_CNT_W-1:0] target;
   always @* begin
      case (faultSel)
         `FAULT_SEL_ONE:  target = `FAULT_NUM_ONE;
         `FAULT_SEL_TWO:  target = `FAULT_NUM_TWO;
         `FAULT_SEL_FOUR: target = `FAULT_NUM_FOUR;
         default:         target = `FAULT_NUM_EIGHT;
      endcase
   end
   // The count of eight wraps to zero, so the target for eight is coded as zero.
   always @* begin
      count_next = count_reg;
      if (convDone) begin
         if (exceed)
            count_next = count_reg + 3'h1;
         else
            count_next = 3'h0;
      end
   end
   assign faultMet = convDone && exceed && ((count_reg + 3'h1) == target);
   always @(posedge clk_sys) begin
      if (sys_rst)
         count_reg <= 3'h0;
      else if (faultMet)
         count_reg <= 3'h0;
      else
         count_reg <= count_next;
   end
endmodule // fault_counter

/* File: hw/eoc_interrupt_reporting.v */
/*
 Interrupt reporting for end-of-conversion mode with latched or transparent comparison.
 Assumes all strobes are one-cycle pulses synchronous to clk_sys from the serial front end.
*/
// Overview of operation
// - End-of-conversion reporting is on when the low-limit top bits equal 11b.
// - In that reporting, every completed conversion makes the alert active.
// - Latched style: config read, non-shutdown write or alert response clears alert.
// - Transparent: high fault sets high flag, clears low, alert and ready set.
// - Transparent: low fault clears high flag, sets low, alert and ready set.
// - Transparent: non-shutdown config write clears alert and ready, flags kept.
// - Transparent: shutdown config write changes nothing.
// - Transparent: alert response changes nothing.
// - Pin is low when active with polarity 0 or inactive with polarity 1.
// - Conversion ready clears right after any configuration read that has no completed conversion in the same cycle.
`timescale 1ns/1ps
`include "eoc_irq_consts.vh"
module eoc_interrupt_reporting (
   // Clock and reset.
   input  wire       clk_sys,
   input  wire       sys_rst,
   // Configuration.
   input  wire [1:0] lowLimitTopBits,
   input  wire       latchSel,
   input  wire       alertPolarity,
   input  wire [1:0] faultSel,
   // Conversion engine.
   input  wire       convDone,
   input  wire       aboveHigh,
   input  wire       belowLow,
   // Host access strobes.
   input  wire       cfgRead,
   input  wire       cfgWrite,
   input  wire [1:0] cfgWriteMode,
   input  wire       cfgWriteLatch,
   input  wire       alertResponse,
   // Status.
   output reg        flagHigh,
   output reg        flagLow,
   output reg        convReady,
   output reg        alertActive,
   output reg        alertPin,
   output wire       eocEnabled
);
   ////////////////////////////////////////////////////////////////////////////////
   // The two limits share one counter design; index 0 watches the high limit.
   localparam NUM_LIMITS = 2;
   localparam HIGH_IDX   = 0;
   localparam LOW_IDX    = 1;

   reg                   flagHigh_next;
   reg                   flagLow_next;
   reg                   convReady_next;
   reg                   alertActive_next;
   reg                   alertPin_next;
   wire [NUM_LIMITS-1:0] exceedVec;
   wire [NUM_LIMITS-1:0] metVec;
   wire                  highMet;
   wire                  lowMet;
   wire                  latchedMode;
   wire                  transparentMode;
   wire                  nonShutdownWrite;
   wire                  readClearsLatched;
   wire                  readClearsEoc;
   wire                  readClearsAlert;
   wire                  writeClearsAlert;
   wire                  responseClearsAlert;
   wire                  leaveClearsAlert;
   wire                  alertClear;
   wire                  readyClear;
   wire                  flagClear;
   genvar                limitIdx;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode.
   assign eocEnabled       = (lowLimitTopBits == `EOC_TOP_BITS_ON);
   assign latchedMode      = latchSel;
   assign transparentMode  = ~latchSel;
   assign nonShutdownWrite = cfgWrite && (cfgWriteMode != `MODE_SHUTDOWN);

   ////////////////////////////////////////////////////////////////////////////////
   // Fault counters, one per limit.
   assign exceedVec[HIGH_IDX] = aboveHigh;
   assign exceedVec[LOW_IDX]  = belowLow;

   generate
      for (limitIdx = 0; limitIdx < NUM_LIMITS; limitIdx = limitIdx + 1) begin : limitCounter
         fault_counter counterU (
            .clk_sys  (clk_sys),
            .sys_rst  (sys_rst),
            .convDone (convDone),
            .exceed   (exceedVec[limitIdx]),
            .faultSel (faultSel),
            .faultMet (metVec[limitIdx])
         );
      end
   endgenerate

   assign highMet = metVec[HIGH_IDX];
   assign lowMet  = metVec[LOW_IDX];

   ////////////////////////////////////////////////////////////////////////////////
   // Host events that clear state. A transparent compare outside end-of-conversion
   // reporting keeps its pin through reads and through writes with cfgWriteLatch set, so those clears are gated.
   assign readClearsLatched   = cfgRead && latchedMode;
   assign readClearsEoc       = cfgRead && eocEnabled;
   assign readClearsAlert     = readClearsLatched || readClearsEoc;
   assign writeClearsAlert    = nonShutdownWrite && eocEnabled;
   assign responseClearsAlert = alertResponse && latchedMode;
   // A latched alert left over from end-of-conversion reporting needs a latch-zero write.
   assign leaveClearsAlert    = cfgWrite && !cfgWriteLatch && !eocEnabled;
   assign alertClear          = readClearsAlert || writeClearsAlert || responseClearsAlert ||
                                leaveClearsAlert;
   assign readyClear          = cfgRead || nonShutdownWrite;
   assign flagClear           = cfgRead && latchedMode;

   ////////////////////////////////////////////////////////////////////////////////
   // High flag. Clears come first and results last, so a result wins over a read.
   always @* begin
      flagHigh_next = flagHigh;
      if (flagClear)
         flagHigh_next = 1'h0;
      if (highMet)
         flagHigh_next = 1'h1;
      else if (lowMet && transparentMode)
         flagHigh_next = 1'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Low flag.
   always @* begin
      flagLow_next = flagLow;
      if (flagClear)
         flagLow_next = 1'h0;
      if (lowMet && latchedMode)
         flagLow_next = 1'h1;
      else if (highMet && transparentMode)
         flagLow_next = 1'h0;
      else if (lowMet)
         flagLow_next = 1'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion ready. A completed conversion wins over a read in the same cycle.
   always @* begin
      convReady_next = convReady;
      if (readyClear)
         convReady_next = 1'h0;
      if (convDone)
         convReady_next = 1'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alert state.
   always @* begin
      alertActive_next = alertActive;
      if (alertClear)
         alertActive_next = 1'h0;
      if (latchedMode) begin
         if (highMet || lowMet)
            alertActive_next = 1'h1;
      end else begin
         if (highMet)
            alertActive_next = 1'h1;
         else if (lowMet)
            alertActive_next = eocEnabled;
      end
      if (convDone && eocEnabled)
         alertActive_next = 1'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin level follows the next alert state, so it moves in the same cycle.
   always @* begin
      case ({alertActive_next, alertPolarity})
         2'h0:    alertPin_next = 1'h1;
         2'h1:    alertPin_next = 1'h0;
         2'h2:    alertPin_next = 1'h0;
         2'h3:    alertPin_next = 1'h1;
         default: alertPin_next = 1'h1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State registers. The pin resets high, the idle level for polarity 0; with
   // polarity 1 it settles on the first edge after reset.
   always @(posedge clk_sys) begin
      if (sys_rst)
         flagHigh <= `FLAG_HIGH_RST;
      else
         flagHigh <= flagHigh_next;
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         flagLow <= `FLAG_LOW_RST;
      else
         flagLow <= flagLow_next;
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         convReady <= `CONV_READY_RST;
      else
         convReady <= convReady_next;
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         alertActive <= `ALERT_ACT_RST;
      else
         alertActive <= alertActive_next;
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         alertPin <= `ALERT_PIN_RST;
      else
         alertPin <= alertPin_next;
   end
endmodule // eoc_interrupt_reporting

/* File: verif/eoc_irq_props.sv */
/* Port checker for the reporting block. Assumes one clock and a sync reset. */
`timescale 1ns/1ps
module eoc_irq_props (
   // Clock and reset.
   input wire       clk_sys,
   input wire       sys_rst,
   // Configuration.
   input wire [1:0] lowLimitTopBits,
   input wire       latchSel,
   input wire       alertPolarity,
   input wire [1:0] faultSel,
   // Conversion engine.
   input wire       convDone,
   input wire       aboveHigh,
   input wire       belowLow,
   // Host access strobes.
   input wire       cfgRead,
   input wire       cfgWrite,
   input wire [1:0] cfgWriteMode,
   input wire       cfgWriteLatch,
   input wire       alertResponse,
   // Status.
   input wire       flagHigh,
   input wire       flagLow,
   input wire       convReady,
   input wire       alertActive,
   input wire       alertPin,
   input wire       eocEnabled
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // A pending conversion or read would mask the event under test.
   wire       tr   = eocEnabled && !latchSel;
   wire       calm = !convDone && !cfgRead;
   wire [3:0] st   = {flagHigh, flagLow, alertActive, convReady};
   a_eoc_decode: assert property (eocEnabled == (lowLimitTopBits == 2'h3))
      else $error("mode decode wrong");
   a_conv_alert: assert property (eocEnabled && convDone |=> alertActive && convReady)
      else $error("no alert on conversion");
   a_latch_clear: assert property (eocEnabled && latchSel && !convDone &&
      (cfgRead || alertResponse || cfgWrite && cfgWriteMode != 2'h0) |=> !alertActive)
      else $error("latched alert kept");
   a_high_fault: assert property (tr && convDone && aboveHigh && faultSel == 2'h0
      |=> flagHigh && !flagLow && alertActive) else $error("high fault wrong");
   a_low_fault: assert property (tr && convDone && belowLow && faultSel == 2'h0
      |=> !flagHigh && flagLow && alertActive) else $error("low fault wrong");
   a_write_clear: assert property (tr && calm && cfgWrite && cfgWriteMode != 2'h0
      |=> st[1:0] == 2'h0 && $stable(st[3:2])) else $error("write clear wrong");
   a_shutdown_hold: assert property (tr && calm && cfgWrite && cfgWriteMode == 2'h0
      |=> $stable(st)) else $error("shutdown write changed state");
   a_response_hold: assert property (tr && calm && alertResponse && !cfgWrite
      |=> $stable(st)) else $error("response changed state");
   a_pin_level: assert property (!$past(sys_rst) && $stable(alertPolarity)
      |-> alertPin == (alertActive ^ !alertPolarity)) else $error("pin level wrong");
   a_read_ready: assert property (cfgRead && !convDone |=> !convReady)
      else $error("ready kept after read");
   c_conv: cover property (eocEnabled && convDone);
   c_resp: cover property (latchSel && alertResponse);
   c_shut: cover property (cfgWrite && cfgWriteMode == 2'h0);
endmodule // eoc_irq_props
bind eoc_interrupt_reporting eoc_irq_props props_u (.clk_sys, .sys_rst, .latchSel,
   .alertPolarity, .convDone, .aboveHigh, .belowLow, .cfgRead, .cfgWrite, .cfgWriteLatch,
   .alertResponse, .eocEnabled, .flagHigh, .flagLow, .convReady, .alertActive, .alertPin,
   .lowLimitTopBits, .faultSel, .cfgWriteMode);

/* File: verif/host_model.sv */
/* Host and converter stand-in, one strobe per call. Assumes a running clk_sys. */
`timescale 1ns/1ps
module host_model (
   // Clock.
   input  wire       clk_sys,
   // Conversion engine stand-in.
   output reg        convDone,
   output reg        aboveHigh,
   output reg        belowLow,
   // Host access strobes.
   output reg        cfgRead,
   output reg        cfgWrite,
   output reg  [1:0] cfgWriteMode,
   output reg        cfgWriteLatch,
   output reg        alertResponse
);
   initial {convDone, aboveHigh, belowLow, cfgRead, cfgWrite, cfgWriteLatch} = 6'h00;
   initial {alertResponse, cfgWriteMode} = 3'h0;
   // Kind 0 converts, 1 reads, 2 writes, 3 answers an alert response.
   task op(input int k, input logic [1:0] m, input logic l);
      @(posedge clk_sys);
      {convDone, cfgRead, cfgWrite, alertResponse} <= {k == 0, k == 1, k == 2, k == 3};
      {aboveHigh, belowLow, cfgWriteMode, cfgWriteLatch} <= {m, m, l};
      @(posedge clk_sys);
      {convDone, cfgRead, cfgWrite, alertResponse} <= 4'h0;
      // Released qualifiers flip so that a stale value is never trusted.
      {aboveHigh, belowLow, cfgWriteMode, cfgWriteLatch} <= ~{m, m, l};
   endtask
endmodule // host_model

/* File: verif/eoc_interrupt_reporting_test.sv */
/* Table of host steps with expected status. Assumes host_model and checker. */
`timescale 1ns/1ps
module eoc_interrupt_reporting_test;
   logic       clk_sys = 1'b0, sys_rst = 1'b1, latchSel = 1'b1, alertPolarity = 1'b0;
   logic [1:0] lowLimitTopBits = 2'h3, faultSel = 2'h0, cfgWriteMode;
   logic       convDone, aboveHigh, belowLow, cfgRead, cfgWrite, cfgWriteLatch, alertResponse;
   logic       flagHigh, flagLow, convReady, alertActive, alertPin, eocEnabled;
   int         nMismatch = 0, cmpCount = 0;
   wire  [5:0] status = {eocEnabled, flagHigh, flagLow, convReady, alertActive, alertPin};
   always #4 clk_sys = ~clk_sys;
   host_model host_u (.clk_sys, .convDone, .aboveHigh, .belowLow, .cfgRead, .cfgWrite,
      .cfgWriteLatch, .alertResponse, .cfgWriteMode);
   eoc_interrupt_reporting dut_u (.clk_sys, .sys_rst, .lowLimitTopBits, .latchSel,
      .alertPolarity, .faultSel, .convDone, .aboveHigh, .belowLow, .cfgRead, .cfgWrite,
      .cfgWriteMode, .cfgWriteLatch, .alertResponse, .flagHigh, .flagLow, .convReady,
      .alertActive, .alertPin, .eocEnabled);
   task chk(input logic [5:0] seen, exp);
      cmpCount++;
      if (seen !== exp) begin
         nMismatch++;
         $display("[FAIL] %0t status %h expected %h", $time, seen, exp);
      end
   endtask
   // Status is eoc, high, low, ready, alert, pin.
   task step(input int k, input logic [1:0] m, input logic l, input logic [5:0] e);
      host_u.op(k, m, l);
      #1 chk(status, e);
   endtask
   task giveVerdict;
      $display("checks %0d mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #400000;
      nMismatch++;
      giveVerdict();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1 chk(status, 6'h21);
      step(0, 2'h0, 1'b0, 6'h26);
      step(1, 2'h0, 1'b0, 6'h21);
      step(0, 2'h2, 1'b0, 6'h36);
      step(3, 2'h0, 1'b0, 6'h35);
      step(0, 2'h0, 1'b0, 6'h36);
      step(2, 2'h1, 1'b1, 6'h31);
      $display("latched test done");
      @(posedge clk_sys) {latchSel, alertPolarity} <= 2'h1;
      step(0, 2'h2, 1'b0, 6'h37);
      step(2, 2'h0, 1'b0, 6'h37);
      step(3, 2'h0, 1'b0, 6'h37);
      step(2, 2'h2, 1'b0, 6'h30);
      step(0, 2'h1, 1'b0, 6'h2f);
      step(1, 2'h0, 1'b0, 6'h28);
      $display("transparent test done");
      @(posedge clk_sys) faultSel <= 2'h1;
      step(0, 2'h2, 1'b0, 6'h2f);
      step(0, 2'h2, 1'b0, 6'h37);
      @(posedge clk_sys) faultSel <= 2'h3;
      repeat (7) step(0, 2'h1, 1'b0, 6'h37);
      step(0, 2'h1, 1'b0, 6'h2f);
      @(posedge clk_sys) faultSel <= 2'h2;
      repeat (3) step(0, 2'h2, 1'b0, 6'h2f);
      step(0, 2'h2, 1'b0, 6'h37);
      $display("fault count test done");
      @(posedge clk_sys) {latchSel, alertPolarity} <= 2'h2;
      step(0, 2'h0, 1'b0, 6'h36);
      @(posedge clk_sys) lowLimitTopBits <= 2'h0;
      step(2, 2'h1, 1'b1, 6'h12);
      step(2, 2'h1, 1'b0, 6'h11);
      $display("mode exit test done");
      @(posedge clk_sys) sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk(status, 6'h01);
      @(posedge clk_sys) sys_rst <= 1'b0;
      step(0, 2'h0, 1'b0, 6'h05);
      $display("reset test done");
      giveVerdict();
   end
endmodule // eoc_interrupt_reporting_test
